// file: ppr_device.sv
// device end: strap latching, pci pin roles, clock out, parity checks
`timescale 1ns/10ps
module ppr_device
    import ppr_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic power_on_reset_in,
    input wire logic link_clk_in,
    input wire logic [STRAP_W-1:0] strap_pins_in,
    input wire logic [CLK_PINS-1:0] clock_pin_enable_field_in,
    input wire logic feedback_clock_enable_bit_in,
    input wire logic [GNT_W-1:0] grant_n_in,
    input wire logic bus_request_n_in,
    input wire logic arbiter_mode_interrupt_output_in,
    input wire logic fatal_error_in,
    output logic [STRAP_W-1:0] straps_out,
    output logic [REQ_W-1:0] request_n_out,
    output logic grant0_n_out,
    output logic [EV_W-1:0] error_event_out,
    ppr_link_if.dev link
);
    logic [STRAP_W-1:0] strap_s1_r;
    logic [STRAP_W-1:0] strap_s2_r;
    logic pon_s1_r;
    logic pon_s2_r;
    logic rst_any;
    logic [STRAP_W-1:0] strap_r;
    logic [4:0] hold_cnt_r;
    logic hold_r;
    logic [3:0] half_cnt_r;
    logic gen_clk_r;
    logic [X_W-1:0] x_src_r;
    logic [REQ_W:0] pin_s1_r;
    logic [REQ_W:0] pin_s2_r;
    logic [EV_W-1:0] ev_s1_r;
    logic [EV_W-1:0] ev_s2_r;
    logic [EV_W-1:0] ev_s3_r;
    logic [X_W-1:0] lx_s1_r;
    logic [X_W-1:0] lx_s2_r;
    logic l_rst;
    logic l_ce;
    logic arb_int;
    logic host_mode;
    logic frame_d_r;
    logic addr_chk_r;
    logic data_chk_r;
    logic special_r;
    logic par_exp_r;
    logic par_bad;
    logic addr_err;
    logic data_err;
    logic perr_r;
    logic serr_r;
    logic [GNT_W-1:0] gnt_r;
    logic req0_r;
    logic arbiter_mode_interrupt_output_r;
    logic [EV_W-1:0] ev_tgl_r;

    //------------------------------------------------------------
    // system clock domain: pin synchronisers
    //------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        strap_s1_r <= strap_pins_in;
        strap_s2_r <= strap_s1_r;
        pon_s1_r <= power_on_reset_in;
        pon_s2_r <= pon_s1_r;
        pin_s1_r <= {link.gnt_n[0], link.req_n};
        pin_s2_r <= pin_s1_r;
        ev_s1_r <= ev_tgl_r;
        ev_s2_r <= ev_s1_r;
    end

    assign rst_any = sys_rst_in | pon_s2_r;

    //------------------------------------------------------------
    // strap capture
    //------------------------------------------------------------
    // track straps until reset release
    always_ff @(posedge clock_in) begin
        if (rst_any) begin
            strap_r <= strap_s2_r;
        end
    end
    assign straps_out = strap_r;
    assign arb_int = strap_r[STRAP_ARB];
    // host strap picks system error direction
    assign host_mode = strap_r[STRAP_HOST];

    //------------------------------------------------------------
    // reset stretch for the link side
    //------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_any) begin
            hold_cnt_r <= 5'h0;
            hold_r <= 1'b1;
        end else if (clk_en_in && hold_r) begin
            hold_cnt_r <= hold_cnt_r + 5'h1;
            hold_r <= (hold_cnt_r != RST_HOLD_LAST);
        end
    end

    //------------------------------------------------------------
    // internal pci clock generator
    //------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_any) begin
            half_cnt_r <= 4'h0;
            gen_clk_r <= strap_s2_r[STRAP_CLK];
        end else if (clk_en_in) begin
            if (!strap_r[STRAP_CLK]) begin
                half_cnt_r <= 4'h0;
                gen_clk_r <= 1'b0;
            end else if (half_cnt_r == PCI_HALF_LAST) begin
                half_cnt_r <= 4'h0;
                gen_clk_r <= ~gen_clk_r;
            end else begin
                half_cnt_r <= half_cnt_r + 4'h1;
            end
        end
    end

    // same clock on both output pins
    assign link.clk_o_dev = {CLK_PINS{gen_clk_r}};
    // per pin enable, cleared bit floats
    assign link.clk_oe_dev = clock_pin_enable_field_in;
    // feedback pin driven only with internal clock
    assign link.fb_o_dev = gen_clk_r;
    assign link.fb_oe_dev = strap_r[STRAP_CLK] & feedback_clock_enable_bit_in;

    //------------------------------------------------------------
    // system side registers and event pulses
    //------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            x_src_r <= {1'b1, 1'b1, 1'b0, 1'b0, 1'b1, {GNT_W{1'b1}}};
            request_n_out <= '1;
            grant0_n_out <= 1'b1;
            ev_s3_r <= ev_s2_r;
            error_event_out <= '0;
        end else if (clk_en_in) begin
            x_src_r <= {clk_en_in, hold_r, fatal_error_in, arbiter_mode_interrupt_output_in,
                        bus_request_n_in, grant_n_in};
            request_n_out <= pin_s2_r[REQ_W-1:0];
            grant0_n_out <= pin_s2_r[REQ_W];
            ev_s3_r <= ev_s2_r;
            error_event_out <= ev_s2_r ^ ev_s3_r;
        end
    end

    //------------------------------------------------------------
    // link clock domain
    //------------------------------------------------------------
    always_ff @(posedge link_clk_in) begin
        lx_s1_r <= x_src_r;
        lx_s2_r <= lx_s1_r;
    end
    assign l_rst = lx_s2_r[X_RST];
    assign l_ce = lx_s2_r[X_CE];

    always_ff @(posedge link_clk_in) begin
        if (l_rst) begin
            frame_d_r <= 1'b1;
            addr_chk_r <= 1'b0;
            data_chk_r <= 1'b0;
            special_r <= 1'b0;
            par_exp_r <= 1'b0;
        end else if (l_ce) begin
            frame_d_r <= link.frame_n;
            addr_chk_r <= frame_d_r & ~link.frame_n;
            data_chk_r <= ~link.irdy_n & ~link.trdy_n;
            // even parity over bus and command
            par_exp_r <= ^{link.ad, link.cbe};
            if (frame_d_r && !link.frame_n) begin
                special_r <= (link.cbe == CMD_SPECIAL);
            end
        end
    end

    assign par_bad = link.par != par_exp_r;
    assign addr_err = addr_chk_r & par_bad;
    assign data_err = data_chk_r & par_bad;

    always_ff @(posedge link_clk_in) begin
        if (l_rst) begin
            perr_r <= 1'b0;
            serr_r <= 1'b0;
            gnt_r <= '1;
            req0_r <= 1'b1;
            arbiter_mode_interrupt_output_r <= 1'b0;
            ev_tgl_r <= '0;
        end else if (l_ce) begin
            // data parity error outside special cycles
            perr_r <= data_err & ~special_r;
            // address, special data or fatal error
            serr_r <= addr_err | (data_err & special_r) | lx_s2_r[X_FATAL];
            gnt_r <= lx_s2_r[X_GNT +: GNT_W];
            req0_r <= lx_s2_r[X_REQ];
            arbiter_mode_interrupt_output_r <= lx_s2_r[X_INT];
            ev_tgl_r[EV_ADDR_PERR] <= ev_tgl_r[EV_ADDR_PERR] ^ addr_err;
            ev_tgl_r[EV_DATA_PERR] <= ev_tgl_r[EV_DATA_PERR] ^ data_err;
            ev_tgl_r[EV_SERR_IN] <= ev_tgl_r[EV_SERR_IN] ^ (host_mode & ~link.serr_n);
        end
    end

    //------------------------------------------------------------
    // pin roles
    //------------------------------------------------------------
    assign link.perr_oe_dev = perr_r & ~x_src_r[X_RST];
    // open drain drive only in satellite mode
    assign link.serr_oe_dev = serr_r & ~host_mode & ~x_src_r[X_RST];
    assign link.req_oe_dev[3:2] = 2'h0;
    assign link.req_o_dev[3:2] = 2'h3;
    // interrupt open drain, floating in reset
    assign link.req_oe_dev[1] = ~arb_int & arbiter_mode_interrupt_output_r & ~x_src_r[X_RST];
    assign link.req_o_dev[1] = 1'b0;
    // own request output, high in reset
    assign link.req_oe_dev[0] = ~arb_int;
    assign link.req_o_dev[0] = req0_r | x_src_r[X_RST];
    // grants driven only with internal arbiter
    assign link.gnt_oe_dev = {GNT_W{arb_int}};
    assign link.gnt_o_dev = gnt_r | {GNT_W{x_src_r[X_RST]}};
endmodule : ppr_device

// file: ppr_pkg.sv
// constants and types shared by both ends of the pci pin role link
//----------------------------------------------------------------
// What this block does
// - clock strap selects internal clock on both pins
// - cleared clock enable bit floats that pin
// - clock pins follow clock strap level in reset
// - internal clock driven and looped on feedback pin
// - software never clears feedback clock enable bit
// - parity even over address data and command
// - upper request pins inputs, pulled up externally
// - request one becomes open drain interrupt output
// - request zero becomes own request output
// - grants outputs internally, inputs with external arbiter
// - system error input in host, open drain otherwise
// - data parity error pin skips special cycles
// - system error reports address, special, fatal errors
// - straps latched when any reset releases
//----------------------------------------------------------------
package ppr_pkg;
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam int REQ_W = 4;
    localparam int GNT_W = 4;
    localparam int CLK_PINS = 2;
    // strap layout
    localparam int STRAP_CLK = 0;
    localparam int STRAP_ARB = 1;
    localparam int STRAP_HOST = 2;
    localparam int STRAP_W = 3;
    localparam logic [STRAP_W-1:0] STRAP_RST = 3'h7;
    // divider half period
    localparam int CLK_IN_MHZ = 125;
    localparam int PCI_CLK_MHZ = 31;
    localparam logic [3:0] PCI_HALF_LAST = 4'(CLK_IN_MHZ / (2 * PCI_CLK_MHZ) - 1);
    // link reset stretch
    localparam logic [4:0] RST_HOLD_LAST = 5'h1f;
    // special cycle command code
    localparam logic [CBE_W-1:0] CMD_SPECIAL = 4'h1;
    // crossing vector layout
    localparam int X_GNT = 0;
    localparam int X_REQ = 4;
    localparam int X_INT = 5;
    localparam int X_FATAL = 6;
    localparam int X_RST = 7;
    localparam int X_CE = 8;
    localparam int X_W = 9;
    // link to system event layout
    localparam int EV_ADDR_PERR = 0;
    localparam int EV_DATA_PERR = 1;
    localparam int EV_SERR_IN = 2;
    localparam int EV_W = 3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_PAR = 4'b1000
    } ppr_state_t;
endpackage : ppr_pkg

// file: ppr_link_if.sv
// pin level carrier between the device end and the far end
`timescale 1ns/10ps
interface ppr_link_if;
    import ppr_pkg::*;
    logic [CLK_PINS-1:0] clk_o_dev;
    logic [CLK_PINS-1:0] clk_oe_dev;
    logic [CLK_PINS-1:0] pci_clock_out;
    logic fb_o_dev;
    logic fb_oe_dev;
    logic fb_o_far;
    logic fb_oe_far;
    logic pci_clock_feedback_pin;
    logic [AD_W-1:0] ad_o_far;
    logic [CBE_W-1:0] cbe_o_far;
    logic par_o_far;
    logic ad_oe_far;
    logic par_oe_far;
    logic [AD_W-1:0] ad;
    logic [CBE_W-1:0] cbe;
    logic par;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic [REQ_W-1:0] req_o_dev;
    logic [REQ_W-1:0] req_oe_dev;
    logic [REQ_W-1:0] req_o_far;
    logic [REQ_W-1:0] req_oe_far;
    logic [REQ_W-1:0] req_n;
    logic [GNT_W-1:0] gnt_o_dev;
    logic [GNT_W-1:0] gnt_oe_dev;
    logic [GNT_W-1:0] gnt_o_far;
    logic [GNT_W-1:0] gnt_oe_far;
    logic [GNT_W-1:0] gnt_n;
    logic perr_oe_dev;
    logic perr_oe_far;
    logic perr_n;
    logic serr_oe_dev;
    logic serr_oe_far;
    logic serr_n;
    //------------------------------------------------------------
    // wire resolution, undriven pins pulled high
    //------------------------------------------------------------
    assign pci_clock_out = (clk_oe_dev & clk_o_dev) | ~clk_oe_dev;
    assign pci_clock_feedback_pin = fb_oe_dev ? fb_o_dev : (fb_oe_far ? fb_o_far : 1'b1);
    assign ad = ad_oe_far ? ad_o_far : '1;
    assign cbe = ad_oe_far ? cbe_o_far : '1;
    assign par = par_oe_far ? par_o_far : 1'b1;
    assign req_n = (req_oe_dev & req_o_dev) | (~req_oe_dev & req_oe_far & req_o_far) | (~req_oe_dev & ~req_oe_far);
    assign gnt_n = (gnt_oe_dev & gnt_o_dev) | (~gnt_oe_dev & gnt_oe_far & gnt_o_far) | (~gnt_oe_dev & ~gnt_oe_far);
    assign perr_n = ~(perr_oe_dev | perr_oe_far);
    assign serr_n = ~(serr_oe_dev | serr_oe_far);
    modport dev (
        output clk_o_dev, clk_oe_dev, fb_o_dev, fb_oe_dev, req_o_dev, req_oe_dev,
        output gnt_o_dev, gnt_oe_dev, perr_oe_dev, serr_oe_dev,
        input pci_clock_out, pci_clock_feedback_pin, ad, cbe, par, frame_n, irdy_n, trdy_n,
        input req_n, gnt_n, perr_n, serr_n
    );
    modport far (
        output fb_o_far, fb_oe_far, ad_o_far, cbe_o_far, par_o_far, ad_oe_far, par_oe_far,
        output frame_n, irdy_n, trdy_n, req_o_far, req_oe_far, gnt_o_far, gnt_oe_far,
        output perr_oe_far, serr_oe_far,
        input pci_clock_out, pci_clock_feedback_pin, ad, cbe, par, req_n, gnt_n, perr_n, serr_n
    );
endinterface : ppr_link_if

// file: ppr_far_end.sv
// far end: pci agent or external arbiter facing the device
`timescale 1ns/10ps
module ppr_far_end
    import ppr_pkg::*;
(
    input wire logic link_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic start_in,
    input wire logic [CBE_W-1:0] cmd_in,
    input wire logic [AD_W-1:0] addr_in,
    input wire logic [AD_W-1:0] data_in,
    input wire logic [CBE_W-1:0] byte_en_in,
    input wire logic bad_parity_in,
    input wire logic drive_clock_in,
    input wire logic [REQ_W-1:0] request_drive_in,
    input wire logic [REQ_W-1:0] request_n_in,
    input wire logic grant_drive_in,
    input wire logic grant0_n_in,
    input wire logic serr_drive_in,
    output logic busy_out,
    output logic perr_seen_out,
    output logic serr_seen_out,
    output logic [GNT_W-1:0] grant_n_out,
    output logic [1:0] device_request_n_out,
    ppr_link_if.far link
);
    ppr_state_t state_r;
    logic [AD_W-1:0] ad_r;
    logic [CBE_W-1:0] cbe_r;
    logic ad_oe_r;
    logic frame_r;
    logic xfer_r;
    logic bad_r;
    logic par_r;
    logic par_oe_r;
    logic [AD_W-1:0] data_r;
    logic [CBE_W-1:0] be_r;

    //------------------------------------------------------------
    // single data phase transfer sequencer
    //------------------------------------------------------------
    always_ff @(posedge link_clk_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
            ad_r <= '0;
            cbe_r <= '0;
            ad_oe_r <= 1'b0;
            frame_r <= 1'b1;
            xfer_r <= 1'b1;
            bad_r <= 1'b0;
            data_r <= '0;
            be_r <= '0;
        end else if (clk_en_in) begin
            case (state_r)
                ST_IDLE: begin
                    if (start_in) begin
                        state_r <= ST_ADDR;
                        ad_r <= addr_in;
                        cbe_r <= cmd_in;
                        ad_oe_r <= 1'b1;
                        frame_r <= 1'b0;
                        bad_r <= bad_parity_in;
                        data_r <= data_in;
                        be_r <= byte_en_in;
                    end
                end
                ST_ADDR: begin
                    state_r <= ST_DATA;
                    ad_r <= data_r;
                    cbe_r <= be_r;
                    frame_r <= 1'b1;
                    xfer_r <= 1'b0;
                end
                ST_DATA: begin
                    state_r <= ST_PAR;
                    ad_oe_r <= 1'b0;
                    xfer_r <= 1'b1;
                end
                ST_PAR: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // parity one clock behind its phase
    //------------------------------------------------------------
    always_ff @(posedge link_clk_in) begin
        if (sys_rst_in) begin
            par_r <= 1'b0;
            par_oe_r <= 1'b0;
        end else if (clk_en_in) begin
            par_r <= (^{ad_r, cbe_r}) ^ bad_r;
            par_oe_r <= ad_oe_r;
        end
    end

    //------------------------------------------------------------
    // observed pins
    //------------------------------------------------------------
    always_ff @(posedge link_clk_in) begin
        if (sys_rst_in) begin
            perr_seen_out <= 1'b0;
            serr_seen_out <= 1'b0;
            grant_n_out <= '1;
            device_request_n_out <= 2'h3;
        end else if (clk_en_in) begin
            perr_seen_out <= ~link.perr_n;
            serr_seen_out <= ~link.serr_n;
            grant_n_out <= link.gnt_n;
            device_request_n_out <= link.req_n[1:0];
        end
    end

    assign busy_out = (state_r != ST_IDLE);
    assign link.ad_o_far = ad_r;
    assign link.cbe_o_far = cbe_r;
    assign link.ad_oe_far = ad_oe_r;
    assign link.par_o_far = par_r;
    assign link.par_oe_far = par_oe_r;
    assign link.frame_n = frame_r;
    assign link.irdy_n = xfer_r;
    assign link.trdy_n = xfer_r;
    // external clock source on the feedback pin
    assign link.fb_o_far = link_clk_in;
    assign link.fb_oe_far = drive_clock_in;
    // all four request pins driven or left to pull-ups
    assign link.req_oe_far = request_drive_in;
    assign link.req_o_far = request_n_in;
    // external arbiter drives grant zero only
    assign link.gnt_oe_far = {{(GNT_W-1){1'b0}}, grant_drive_in};
    assign link.gnt_o_far = {{(GNT_W-1){1'b1}}, grant0_n_in};
    assign link.perr_oe_far = 1'b0;
    // host side agent may pull system error
    assign link.serr_oe_far = serr_drive_in;
endmodule : ppr_far_end

// file: ppr_link_sva.sv
// assertions on the pci pin role link
`timescale 1ns/10ps
module ppr_link_sva
    import ppr_pkg::*;
(
    input wire logic sys_rst_in,
    input wire logic pci_clock_feedback_pin,
    input wire logic [STRAP_W-1:0] straps_out,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic trdy_n,
    input wire logic [AD_W-1:0] ad,
    input wire logic [CBE_W-1:0] cbe,
    input wire logic par,
    input wire logic perr_n,
    input wire logic serr_n,
    input wire logic [REQ_W-1:0] req_o_dev,
    input wire logic [REQ_W-1:0] req_oe_dev,
    input wire logic [GNT_W-1:0] gnt_oe_dev,
    input wire logic fb_oe_dev,
    input wire logic serr_oe_dev
);
    default clocking ck @(posedge pci_clock_feedback_pin);
    endclocking
    default disable iff (sys_rst_in);
    logic exp_par_r;
    logic addr_r;
    logic data_r;
    logic [CBE_W-1:0] cmd_r;
    logic sat;
    logic a_bad;
    logic d_bad;
    logic spec;
    //------------------------------------------------------------
    // phase tracking on the link clock
    //------------------------------------------------------------
    always_ff @(posedge pci_clock_feedback_pin) begin
        exp_par_r <= ^{ad, cbe};
        addr_r <= $fell(frame_n);
        data_r <= !irdy_n && !trdy_n;
        if ($fell(frame_n)) begin
            cmd_r <= cbe;
        end
    end
    assign sat = !straps_out[STRAP_HOST];
    assign a_bad = addr_r && (par != exp_par_r);
    assign d_bad = data_r && (par != exp_par_r);
    assign spec = (cmd_r == CMD_SPECIAL);
    chk_serr_addr: assert property (
        a_bad && sat |-> ##[1:2] !serr_n) else $error("no serr after address parity error");
    chk_perr_data: assert property (
        d_bad && !spec |-> ##[1:2] !perr_n) else $error("no perr after data parity error");
    chk_perr_special: assert property (
        d_bad && spec |-> perr_n [*3]) else $error("perr on special cycle");
    chk_serr_special: assert property (
        d_bad && spec && sat |-> ##[1:2] !serr_n) else $error("no serr on special cycle error");
    chk_perr_good: assert property (
        data_r && (par == exp_par_r) |-> ##1 perr_n ##1 perr_n) else $error("perr on even parity");
    chk_serr_host: assert property (
        !sat |-> !serr_oe_dev) else $error("serr driven in host mode");
    chk_req_internal: assert property (
        straps_out[STRAP_ARB] |-> req_oe_dev == 4'h0) else $error("request pin driven by internal arbiter");
    chk_req_external: assert property (
        !straps_out[STRAP_ARB] |-> req_oe_dev[0] && req_oe_dev[3:2] == 2'h0) else $error("request roles wrong");
    chk_req1_drain: assert property (
        req_oe_dev[1] |-> !req_o_dev[1] && !straps_out[STRAP_ARB]) else $error("request one not open drain");
    chk_gnt_roles: assert property (
        gnt_oe_dev == (straps_out[STRAP_ARB] ? 4'hf : 4'h0)) else $error("grant pin direction wrong");
    chk_fb_role: assert property (
        fb_oe_dev == straps_out[STRAP_CLK]) else $error("feedback pin direction wrong");
    cov_perr: cover property (d_bad && !spec);
    cov_special: cover property (d_bad && spec);
    cov_int_clk: cover property (fb_oe_dev && !serr_n);
endmodule : ppr_link_sva

// file: pci_pin_role_config_bench.sv
// bench joining the device end and the far end
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %h got %h", n, e, g); end end
module pci_pin_role_config_bench;
    import ppr_pkg::*;
    logic clock_in = 1'b0;
    logic lclk = 1'b0;
    logic sys_rst_in = 1'b1;
    logic far_rst = 1'b1;
    logic [STRAP_W-1:0] straps = 3'h0;
    logic [CLK_PINS-1:0] ck_en = 2'h3;
    logic [GNT_W-1:0] grant_n = 4'hf;
    logic bus_req_n = 1'b1;
    logic int_out = 1'b0;
    logic fatal = 1'b0;
    logic start = 1'b0;
    logic [CBE_W-1:0] cmd = 4'h0;
    logic [AD_W-1:0] word = 32'h5a0f_c321;
    logic bad = 1'b0;
    logic [REQ_W-1:0] rq_drv = 4'h0;
    logic [REQ_W-1:0] rq_lvl = 4'hf;
    logic g_drv = 1'b0;
    logic g0_n = 1'b1;
    logic serr_drv = 1'b0;
    logic far_clk;
    logic [STRAP_W-1:0] straps_out;
    logic [REQ_W-1:0] request_n_out;
    logic grant0_n_out;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] ev_acc;
    logic perr_seen;
    logic serr_seen;
    logic [1:0] seen_acc;
    logic busy;
    logic [GNT_W-1:0] far_gnt_n;
    logic [1:0] far_req_n;
    logic p;
    logic same;
    int checks = 0;
    int n_mismatch = 0;
    int cycles = 0;
    int n_tog;
    //------------------------------------------------------------
    // clocks, ends and checker
    //------------------------------------------------------------
    initial forever #4 clock_in = ~clock_in;
    initial begin
        #3;
        forever #7.5 lclk = ~lclk;
    end
    ppr_link_if link ();
    assign far_clk = straps[STRAP_CLK] ? link.pci_clock_feedback_pin : lclk;
    ppr_device i_ppr_device (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
        .power_on_reset_in(1'b0), .link_clk_in(link.pci_clock_feedback_pin), .strap_pins_in(straps),
        .clock_pin_enable_field_in(ck_en), .feedback_clock_enable_bit_in(1'b1), .grant_n_in(grant_n),
        .bus_request_n_in(bus_req_n), .arbiter_mode_interrupt_output_in(int_out), .fatal_error_in(fatal),
        .straps_out(straps_out), .request_n_out(request_n_out), .grant0_n_out(grant0_n_out),
        .error_event_out(ev), .link(link.dev));
    ppr_far_end i_ppr_far_end (.link_clk_in(far_clk), .sys_rst_in(far_rst), .clk_en_in(1'b1),
        .start_in(start), .cmd_in(cmd), .addr_in(word), .data_in(~word), .byte_en_in(word[3:0]),
        .bad_parity_in(bad), .drive_clock_in(!straps[STRAP_CLK]), .request_drive_in(rq_drv),
        .request_n_in(rq_lvl), .grant_drive_in(g_drv), .grant0_n_in(g0_n), .serr_drive_in(serr_drv),
        .busy_out(busy), .perr_seen_out(perr_seen), .serr_seen_out(serr_seen), .grant_n_out(far_gnt_n),
        .device_request_n_out(far_req_n), .link(link.far));
    ppr_link_sva i_ppr_link_sva (.sys_rst_in(sys_rst_in),
        .pci_clock_feedback_pin(link.pci_clock_feedback_pin), .straps_out(straps_out), .frame_n(link.frame_n),
        .irdy_n(link.irdy_n), .trdy_n(link.trdy_n), .ad(link.ad), .cbe(link.cbe), .par(link.par),
        .perr_n(link.perr_n), .serr_n(link.serr_n), .req_o_dev(link.req_o_dev), .req_oe_dev(link.req_oe_dev),
        .gnt_oe_dev(link.gnt_oe_dev), .fb_oe_dev(link.fb_oe_dev), .serr_oe_dev(link.serr_oe_dev));
    always @(posedge far_clk) seen_acc <= start ? 2'h0 : seen_acc | {serr_seen, perr_seen};
    always @(posedge clock_in) ev_acc <= start ? 3'h0 : ev_acc | ev;
    //------------------------------------------------------------
    // tasks
    //------------------------------------------------------------
    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic wait_ck(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : wait_ck
    task automatic reset_to(input logic [STRAP_W-1:0] s);
        @(posedge clock_in);
        straps <= s;
        sys_rst_in <= 1'b1;
        far_rst <= 1'b1;
        wait_ck(3);
        `CHK("clock level", {2{s[STRAP_CLK]}}, link.pci_clock_out)
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        straps <= s ^ 3'h6;
        wait_ck(45);
        @(posedge far_clk);
        far_rst <= 1'b0;
        wait_ck(30);
        `CHK("straps", s, straps_out)
    endtask : reset_to
    task automatic xfer(input logic [CBE_W-1:0] c, input logic b, input logic [1:0] es, input logic [EV_W-1:0] ee);
        @(posedge far_clk);
        cmd <= c;
        bad <= b;
        start <= 1'b1;
        @(posedge far_clk);
        start <= 1'b0;
        #1;
        `CHK("busy", 1'b1, busy)
        repeat (12) @(posedge far_clk);
        wait_ck(10);
        `CHK("far seen", es, seen_acc)
        `CHK("events", ee, ev_acc)
    endtask : xfer
    task automatic ext_pins();
        @(posedge clock_in);
        bus_req_n <= 1'b0;
        int_out <= 1'b1;
        @(posedge far_clk);
        g_drv <= 1'b1;
        g0_n <= 1'b0;
        wait_ck(20);
        `CHK("fb oe", 1'b0, link.fb_oe_dev)
        `CHK("req pins", 4'hc, link.req_n)
        `CHK("far req", 2'h0, far_req_n)
        `CHK("gnt pins", 4'he, link.gnt_n)
        `CHK("gnt0", 1'b0, grant0_n_out)
        @(posedge clock_in);
        bus_req_n <= 1'b1;
        int_out <= 1'b0;
        fatal <= 1'b1;
        wait_ck(20);
        `CHK("req idle", 4'hf, link.req_n)
        `CHK("serr fatal", 1'b0, link.serr_n)
        @(posedge clock_in);
        fatal <= 1'b0;
        wait_ck(20);
        `CHK("serr off", 1'b1, link.serr_n)
    endtask : ext_pins
    task automatic int_pins();
        n_tog = 0;
        same = 1'b1;
        @(negedge clock_in);
        p = link.pci_clock_out[0];
        repeat (40) begin
            @(negedge clock_in);
            if (link.pci_clock_out[0] !== p) n_tog++;
            if (link.pci_clock_out[1] !== link.pci_clock_out[0]) same = 1'b0;
            p = link.pci_clock_out[0];
        end
        `CHK("clock toggles", 20, n_tog)
        `CHK("both pins", 1'b1, same)
        `CHK("fb oe", 1'b1, link.fb_oe_dev)
        @(posedge clock_in);
        ck_en <= 2'h2;
        grant_n <= 4'ha;
        wait_ck(6);
        `CHK("clock oe", 2'h2, link.clk_oe_dev)
        `CHK("clock float", 1'b1, link.pci_clock_out[0])
        ck_en <= 2'h3;
        @(posedge far_clk);
        rq_drv <= 4'hf;
        rq_lvl <= 4'h6;
        wait_ck(16);
        `CHK("req in", 4'h6, request_n_out)
        `CHK("far gnt", 4'ha, far_gnt_n)
        @(posedge far_clk);
        rq_drv <= 4'h0;
        serr_drv <= 1'b1;
        wait_ck(16);
        `CHK("serr in", 1'b1, ev_acc[EV_SERR_IN])
        `CHK("serr oe", 1'b0, link.serr_oe_dev)
        @(posedge far_clk);
        serr_drv <= 1'b0;
        wait_ck(16);
    endtask : int_pins
    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        reset_to(3'h0);
        ext_pins();
        xfer(4'h7, 1'b0, 2'h0, 3'h0);
        xfer(4'h6, 1'b1, 2'h3, 3'h3);
        xfer(CMD_SPECIAL, 1'b1, 2'h2, 3'h3);
        reset_to(3'h7);
        int_pins();
        xfer(4'h7, 1'b0, 2'h0, 3'h0);
        xfer(4'h6, 1'b1, 2'h1, 3'h3);
        xfer(CMD_SPECIAL, 1'b1, 2'h0, 3'h3);
        print_verdict();
    end
endmodule : pci_pin_role_config_bench
